// *** verilog/aipc_bank.sv ***
// Contract
// - Lane mapping codes 1..4, others unused
// - New mapping acts only after fuse load
// - Fuse load returns written registers except 0x07 to defaults
// - Fuse mapping applied; readback zero until written
// - Fuse mode applied; readback zero until written
// - Mode select overrides only with enable set
// - Mode codes 3,4,5 valid, others unused
// - Bit 5 powers down sampling clock buffer
// - Bit 4 powers down reference amplifier
// - Bits 2,1 power down channels A,B
// - Bit 0 global sleep, masked by 0x0D
// - Each driver disable bit powers one buffer
// - Driver bits map to named lane pins
// - Bit clock buffers have separate enables
// - Mask register bits 3,2,1, reset zero
// - Keep-awake masks spare clock buffer, amplifier
// - Bandgap sleeps only when allow bit set
// - Sleep pin enters global sleep when selected
`timescale 1ns/100ps
module aipc_bank (
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  input  wire logic                 sen_n_in,
  input  wire logic                 sclk_in,
  input  wire logic                 sdi_in,
  input  wire logic [2:0]           fuse_lane_mapping_in,
  input  wire logic [2:0]           fuse_interface_mode_in,
  input  wire logic                 sync_or_sleep_pin_in,
  input  wire logic                 sync_pin_selects_sync_in,
  input  wire logic                 bit_clock_input_enable_a_in,
  input  wire logic                 bit_clock_input_enable_b_in,
  input  wire logic                 bit_clock_output_off_in,
  output logic                      sdo_out,
  output aipc_pkg::aipc_power_s     power_out,
  output aipc_pkg::aipc_iface_s     iface_out,
  output logic [23:0]               output_driver_disable_out,
  output logic                      bit_clock_input_off_out,
  output logic                      bit_clock_output_off_out
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic mapping_valid(input logic [2:0] code);
    mapping_valid = (code == aipc_pkg::MAP_TWO_18_14) || (code == aipc_pkg::MAP_TWO_20_16) ||
                    (code == aipc_pkg::MAP_ONE_LANE) || (code == aipc_pkg::MAP_HALF_LANE);
  endfunction

  function automatic logic mode_valid(input logic [2:0] code);
    mode_valid = (code == aipc_pkg::MODE_TWO) || (code == aipc_pkg::MODE_ONE) ||
                 (code == aipc_pkg::MODE_HALF);
  endfunction

  function automatic logic reg_hit(input logic       strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
    reg_hit = strobe && (addr == target);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic                                   sclk_prev;
  logic [aipc_pkg::CNT_W-1:0]             bit_count;
  logic [aipc_pkg::FRAME_BITS-2:0]        shift_in;
  logic [aipc_pkg::DATA_W-1:0]            read_shift;
  logic [7:0]                             if_config;
  logic [7:0]                             power_ctrl;
  logic [7:0]                             driver_dis_0;
  logic [7:0]                             driver_dis_1;
  logic [7:0]                             driver_dis_2;
  logic [7:0]                             sleep_mask;
  logic                                   mapping_written;
  logic                                   fuse_load_pending;
  logic [2:0]                             active_mapping;
  logic [2:0]                             fuse_mode;
  logic                                   write_strobe;
  logic [7:0]                             write_addr;
  logic [7:0]                             write_data;

  logic                                   sclk_rise;
  logic                                   sclk_fall;
  logic [aipc_pkg::FRAME_BITS-1:0]        next_frame;
  logic [aipc_pkg::CNT_W-1:0]             next_count;
  logic                                   global_sleep;

  assign sclk_rise    = sclk_in & ~sclk_prev;
  assign sclk_fall    = ~sclk_in & sclk_prev;
  assign next_frame   = {shift_in, sdi_in};
  assign next_count   = bit_count + aipc_pkg::CNT_W'(1);
  assign global_sleep = power_ctrl[aipc_pkg::GLOBAL_BIT] |
                        (sync_or_sleep_pin_in & ~sync_pin_selects_sync_in);

  // ****************************************
  // Serial port receive
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sclk_prev    <= 1'b0;
      bit_count    <= '0;
      shift_in     <= '0;
      write_strobe <= 1'b0;
      write_addr   <= aipc_pkg::REG_RESET;
      write_data   <= aipc_pkg::REG_RESET;
    end else begin
      sclk_prev    <= sclk_in;
      write_strobe <= 1'b0;
      if (sen_n_in) begin
        bit_count <= '0;
      end else if (sclk_rise && bit_count < aipc_pkg::CNT_W'(aipc_pkg::FRAME_BITS)) begin
        shift_in  <= next_frame[aipc_pkg::FRAME_BITS-2:0];
        bit_count <= next_count;
        if (next_count == aipc_pkg::CNT_W'(aipc_pkg::FRAME_BITS)) begin
          write_strobe <= ~next_frame[aipc_pkg::FRAME_BITS-1];
          write_addr   <= next_frame[aipc_pkg::FRAME_BITS-2 -: aipc_pkg::ADDR_W];
          write_data   <= next_frame[aipc_pkg::DATA_W-1:0];
        end
      end
    end
  end

  // ****************************************
  // Serial port read data
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      read_shift <= aipc_pkg::REG_RESET;
      sdo_out    <= 1'b0;
    end else if (sen_n_in) begin
      sdo_out <= 1'b0;
    end else if (sclk_rise && next_count == aipc_pkg::CNT_W'(aipc_pkg::HDR_BITS)) begin
      unique case (next_frame[aipc_pkg::ADDR_W-1:0])
        aipc_pkg::OUTPUT_INTERFACE_CONFIG: read_shift <= if_config;
        aipc_pkg::POWER_DOWN_CONTROL:      read_shift <= power_ctrl;
        aipc_pkg::OUTPUT_DRIVER_DISABLE_0: read_shift <= driver_dis_0;
        aipc_pkg::OUTPUT_DRIVER_DISABLE_1: read_shift <= driver_dis_1;
        aipc_pkg::OUTPUT_DRIVER_DISABLE_2: read_shift <= driver_dis_2;
        aipc_pkg::GLOBAL_SLEEP_MASK:       read_shift <= sleep_mask;
        default:                           read_shift <= aipc_pkg::REG_RESET;
      endcase
    end else if (sclk_fall && bit_count >= aipc_pkg::CNT_W'(aipc_pkg::HDR_BITS) &&
                 bit_count < aipc_pkg::CNT_W'(aipc_pkg::FRAME_BITS)) begin
      sdo_out    <= read_shift[aipc_pkg::DATA_W-1];
      read_shift <= {read_shift[aipc_pkg::DATA_W-2:0], 1'b0};
    end
  end

  // ****************************************
  // Fuse load command
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fuse_load_pending <= 1'b1;
    end else begin
      fuse_load_pending <= reg_hit(write_strobe, write_addr, aipc_pkg::FUSE_LOAD_COMMAND) &&
                           write_data[aipc_pkg::FUSE_LOAD_BIT];
    end
  end

  // ****************************************
  // Interface configuration register
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      if_config       <= aipc_pkg::REG_RESET;
      mapping_written <= 1'b0;
    end else if (reg_hit(write_strobe, write_addr, aipc_pkg::OUTPUT_INTERFACE_CONFIG)) begin
      if_config       <= write_data & aipc_pkg::IF_CONFIG_MASK;
      mapping_written <= 1'b1;
    end
  end

  // ****************************************
  // Fuse default interface mode
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fuse_mode <= aipc_pkg::MODE_NONE;
    end else if (fuse_load_pending) begin
      fuse_mode <= fuse_interface_mode_in;
    end
  end

  // ****************************************
  // Active lane mapping
  // ****************************************
  // Written mapping wins only when valid, fuse code otherwise
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      active_mapping <= aipc_pkg::MAP_NONE;
    end else if (fuse_load_pending) begin
      if (mapping_written && mapping_valid(if_config[aipc_pkg::MAPPING_LSB +: 3])) begin
        active_mapping <= if_config[aipc_pkg::MAPPING_LSB +: 3];
      end else begin
        active_mapping <= fuse_lane_mapping_in;
      end
    end
  end

  // ****************************************
  // Power control register
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in || fuse_load_pending) begin
      power_ctrl <= aipc_pkg::REG_RESET;
    end else if (reg_hit(write_strobe, write_addr, aipc_pkg::POWER_DOWN_CONTROL)) begin
      power_ctrl <= write_data & aipc_pkg::POWER_MASK;
    end
  end

  // ****************************************
  // Output driver disable registers
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in || fuse_load_pending) begin
      driver_dis_0 <= aipc_pkg::REG_RESET;
      driver_dis_1 <= aipc_pkg::REG_RESET;
      driver_dis_2 <= aipc_pkg::REG_RESET;
    end else begin
      if (reg_hit(write_strobe, write_addr, aipc_pkg::OUTPUT_DRIVER_DISABLE_0)) begin
        driver_dis_0 <= write_data;
      end
      if (reg_hit(write_strobe, write_addr, aipc_pkg::OUTPUT_DRIVER_DISABLE_1)) begin
        driver_dis_1 <= write_data;
      end
      if (reg_hit(write_strobe, write_addr, aipc_pkg::OUTPUT_DRIVER_DISABLE_2)) begin
        driver_dis_2 <= write_data;
      end
    end
  end

  // ****************************************
  // Global sleep mask register
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in || fuse_load_pending) begin
      sleep_mask <= aipc_pkg::REG_RESET;
    end else if (reg_hit(write_strobe, write_addr, aipc_pkg::GLOBAL_SLEEP_MASK)) begin
      sleep_mask <= write_data & aipc_pkg::SLEEP_MASK_W;
    end
  end

  // ****************************************
  // Interface mode output
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      iface_out <= '0;
    end else begin
      iface_out.lane_mapping <= active_mapping;
      if (if_config[aipc_pkg::OVERRIDE_BIT] && mode_valid(if_config[aipc_pkg::MODE_LSB +: 3])) begin
        iface_out.interface_mode <= if_config[aipc_pkg::MODE_LSB +: 3];
      end else begin
        iface_out.interface_mode <= fuse_mode;
      end
    end
  end

  // ****************************************
  // Power down outputs
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      power_out <= '0;
    end else begin
      power_out.clock_buffer_off    <= power_ctrl[aipc_pkg::CLKBUF_OFF_BIT] |
                                       (global_sleep & ~sleep_mask[aipc_pkg::KEEP_CLKBUF_BIT]);
      power_out.reference_amp_off   <= power_ctrl[aipc_pkg::REFERENCE_AMPLIFIER_OFF_BIT] |
                                       (global_sleep & ~sleep_mask[aipc_pkg::KEEP_REFERENCE_AMPLIFIER_BIT]);
      power_out.bandgap_off         <= global_sleep & sleep_mask[aipc_pkg::BANDGAP_BIT];
      power_out.channel_a_off       <= power_ctrl[aipc_pkg::CHAN_A_OFF_BIT] | global_sleep;
      power_out.channel_b_off       <= power_ctrl[aipc_pkg::CHAN_B_OFF_BIT] | global_sleep;
      power_out.global_sleep_active <= global_sleep;
    end
  end

  // ****************************************
  // Output driver enables
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      output_driver_disable_out <= '0;
    end else begin
      output_driver_disable_out <= {driver_dis_0, driver_dis_1, driver_dis_2};
    end
  end

  // ****************************************
  // Bit clock buffer enables
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bit_clock_input_off_out  <= 1'b0;
      bit_clock_output_off_out <= 1'b0;
    end else begin
      bit_clock_input_off_out  <= driver_dis_0[aipc_pkg::BIT_CLOCK_IN_POS] |
                                  ~bit_clock_input_enable_a_in | ~bit_clock_input_enable_b_in;
      bit_clock_output_off_out <= bit_clock_output_off_in;
    end
  end

endmodule

// *** verilog/aipc_pkg.sv ***
package aipc_pkg;

  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned HDR_BITS   = 1 + ADDR_W;
  localparam int unsigned FRAME_BITS = HDR_BITS + DATA_W;
  localparam int unsigned CNT_W      = 5;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OUTPUT_INTERFACE_CONFIG = 8'h07;
  localparam logic [7:0] POWER_DOWN_CONTROL      = 8'h08;
  localparam logic [7:0] OUTPUT_DRIVER_DISABLE_0 = 8'h0A;
  localparam logic [7:0] OUTPUT_DRIVER_DISABLE_1 = 8'h0B;
  localparam logic [7:0] OUTPUT_DRIVER_DISABLE_2 = 8'h0C;
  localparam logic [7:0] GLOBAL_SLEEP_MASK       = 8'h0D;
  localparam logic [7:0] FUSE_LOAD_COMMAND       = 8'h13;

  // ****************************************
  // Reset values and writable-bit masks
  // ****************************************
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] IF_CONFIG_MASK = 8'hEF;
  localparam logic [7:0] POWER_MASK     = 8'h37;
  localparam logic [7:0] SLEEP_MASK_W   = 8'h0E;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned MAPPING_LSB      = 5;
  localparam int unsigned OVERRIDE_BIT     = 3;
  localparam int unsigned MODE_LSB         = 0;
  localparam int unsigned CLKBUF_OFF_BIT   = 5;
  localparam int unsigned REFERENCE_AMPLIFIER_OFF_BIT   = 4;
  localparam int unsigned CHAN_A_OFF_BIT   = 2;
  localparam int unsigned CHAN_B_OFF_BIT   = 1;
  localparam int unsigned GLOBAL_BIT       = 0;
  localparam int unsigned KEEP_CLKBUF_BIT  = 3;
  localparam int unsigned KEEP_REFERENCE_AMPLIFIER_BIT  = 2;
  localparam int unsigned BANDGAP_BIT      = 1;
  localparam int unsigned FUSE_LOAD_BIT    = 0;
  localparam int unsigned BIT_CLOCK_IN_POS = 3;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [2:0] {
    MAP_NONE      = 3'h0,
    MAP_TWO_18_14 = 3'h1,
    MAP_TWO_20_16 = 3'h2,
    MAP_ONE_LANE  = 3'h3,
    MAP_HALF_LANE = 3'h4
  } aipc_mapping_e;

  typedef enum logic [2:0] {
    MODE_NONE = 3'h0,
    MODE_TWO  = 3'h3,
    MODE_ONE  = 3'h4,
    MODE_HALF = 3'h5
  } aipc_mode_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic clock_buffer_off;
    logic reference_amp_off;
    logic bandgap_off;
    logic channel_a_off;
    logic channel_b_off;
    logic global_sleep_active;
  } aipc_power_s;

  typedef struct packed {
    logic [2:0] lane_mapping;
    logic [2:0] interface_mode;
  } aipc_iface_s;

endpackage

// *** verif/aipc_bank_monitor.sv ***
`timescale 1ns/100ps
module aipc_bank_monitor (
  input logic                  clock_in,
  input logic                  rst_in,
  input logic                  sen_n_in,
  input logic [2:0]            fuse_lane_mapping_in,
  input logic [2:0]            fuse_interface_mode_in,
  input logic                  sync_or_sleep_pin_in,
  input logic                  sync_pin_selects_sync_in,
  input logic                  bit_clock_input_enable_a_in,
  input logic                  bit_clock_input_enable_b_in,
  input logic                  bit_clock_output_off_in,
  input aipc_pkg::aipc_power_s power_out,
  input aipc_pkg::aipc_iface_s iface_out,
  input logic [23:0]           output_driver_disable_out,
  input logic                  bit_clock_input_off_out,
  input logic                  bit_clock_output_off_out
);
  // ****************************************
  // Startup settling counter
  // ****************************************
  logic [2:0] up_cnt;
  logic       settled;
  assign settled = (up_cnt == 3'h7);
  always_ff @(posedge clock_in) begin
    if (rst_in) up_cnt <= 3'h0;
    else if (!settled) up_cnt <= up_cnt + 3'h1;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_pin_sleep;
    (sync_or_sleep_pin_in && !sync_pin_selects_sync_in) [*4];
  endsequence
  sequence s_clk_en_steady;
    (bit_clock_input_enable_a_in && bit_clock_input_enable_b_in && $stable(output_driver_disable_out[19])) [*3];
  endsequence
  sequence s_port_idle;
    (settled && sen_n_in) [*3];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_sleep_kills_chans: assert property (power_out.global_sleep_active |->
    power_out.channel_a_off && power_out.channel_b_off) else $error("channels awake in sleep");
  a_bandgap_needs_sleep: assert property (power_out.bandgap_off |->
    power_out.global_sleep_active) else $error("bandgap off outside sleep");
  a_pin_sleep: assert property (s_pin_sleep |-> power_out.global_sleep_active)
    else $error("sleep pin ignored");
  a_bitclk_in_gate: assert property ((!bit_clock_input_enable_a_in || !bit_clock_input_enable_b_in) [*2]
    |-> bit_clock_input_off_out) else $error("bit clock input on while disabled");
  a_bitclk_in_map: assert property (s_clk_en_steady |->
    bit_clock_input_off_out == output_driver_disable_out[19]) else $error("bit clock input off mismatch");
  a_bitclk_out_follow: assert property ($stable(bit_clock_output_off_in) [*2] |->
    bit_clock_output_off_out == bit_clock_output_off_in) else $error("bit clock output off mismatch");
  a_drivers_hold: assert property (s_port_idle |-> $stable(output_driver_disable_out))
    else $error("driver disables moved while port idle");
  a_iface_hold: assert property (s_port_idle |-> $stable(iface_out))
    else $error("interface changed while port idle");
  a_mode_legal: assert property (settled |-> iface_out.interface_mode inside {3'h3, 3'h4, 3'h5}
    || iface_out.interface_mode == fuse_interface_mode_in) else $error("illegal interface mode");
  a_map_legal: assert property (settled |-> iface_out.lane_mapping inside {3'h1, 3'h2, 3'h3, 3'h4}
    || iface_out.lane_mapping == fuse_lane_mapping_in) else $error("illegal lane mapping");
endmodule
bind aipc_bank aipc_bank_monitor i_mon (.clock_in(clock_in), .rst_in(rst_in), .sen_n_in(sen_n_in),
  .fuse_lane_mapping_in(fuse_lane_mapping_in), .fuse_interface_mode_in(fuse_interface_mode_in),
  .sync_or_sleep_pin_in(sync_or_sleep_pin_in), .sync_pin_selects_sync_in(sync_pin_selects_sync_in),
  .bit_clock_input_enable_a_in(bit_clock_input_enable_a_in), .bit_clock_input_enable_b_in(bit_clock_input_enable_b_in),
  .bit_clock_output_off_in(bit_clock_output_off_in), .power_out(power_out), .iface_out(iface_out),
  .output_driver_disable_out(output_driver_disable_out), .bit_clock_input_off_out(bit_clock_input_off_out),
  .bit_clock_output_off_out(bit_clock_output_off_out));

// *** verif/aipc_host_model.sv ***
`timescale 1ns/100ps
module aipc_host_model (
  input  wire logic clock_in,
  input  wire logic sdo_in,
  output logic      sen_n_out,
  output logic      sclk_out,
  output logic      sdi_out
);
  initial begin
    sen_n_out = 1'b1;
    sclk_out  = 1'b0;
    sdi_out   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // One frame, MSB first, sclk high and low two clocks each
  task automatic xfer(input logic [16:0] frame, output logic [7:0] rdata);
    rdata     = 8'h00;
    sen_n_out = 1'b0;
    for (int i = 16; i >= 0; i--) begin
      sclk_out = 1'b0;
      sdi_out  = frame[i];
      tick(2);
      if (i < 8) rdata[i] = sdo_in;
      sclk_out = 1'b1;
      tick(2);
    end
    sclk_out = 1'b0;
    tick(1);
    sen_n_out = 1'b1;
    // Released data line does not keep its last level
    sdi_out = ~sdi_out;
    tick(3);
  endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/100ps
module tb;
  logic [2:0]            fuse_map  = 3'h3;
  logic [2:0]            fuse_mode = 3'h4;
  logic                  clock_in = 1'b0;
  logic                  rst_in   = 1'b1;
  logic                  pin      = 1'b0;
  logic                  sel      = 1'b1;
  logic                  en_a     = 1'b1;
  logic                  en_b     = 1'b1;
  logic                  bco      = 1'b0;
  logic                  sen_n, sclk, sdi, sdo, bci_off, bco_off;
  aipc_pkg::aipc_power_s pwr;
  aipc_pkg::aipc_iface_s ifc;
  logic [23:0]           odd;
  int                    num_errors  = 0;
  int                    checks_done = 0;
  aipc_bank i_dut (.clock_in(clock_in), .rst_in(rst_in), .sen_n_in(sen_n), .sclk_in(sclk), .sdi_in(sdi),
    .fuse_lane_mapping_in(fuse_map), .fuse_interface_mode_in(fuse_mode), .sync_or_sleep_pin_in(pin),
    .sync_pin_selects_sync_in(sel), .bit_clock_input_enable_a_in(en_a), .bit_clock_input_enable_b_in(en_b),
    .bit_clock_output_off_in(bco), .sdo_out(sdo), .power_out(pwr), .iface_out(ifc),
    .output_driver_disable_out(odd), .bit_clock_input_off_out(bci_off), .bit_clock_output_off_out(bco_off));
  aipc_host_model i_host (.clock_in(clock_in), .sdo_in(sdo), .sen_n_out(sen_n), .sclk_out(sclk), .sdi_out(sdi));
  initial forever #10 clock_in = ~clock_in;
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_host.xfer({1'b0, a, d}, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    i_host.xfer({1'b1, a, 8'h00}, r);
    check({16'h0000, r}, {16'h0000, exp});
  endtask
  task automatic print_verdict;
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] regs [7] = '{8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h20};
    check({18'h00000, ifc}, {18'h00000, fuse_map, fuse_mode});
    foreach (regs[i]) rd_chk(regs[i], 8'h00);
    check({18'h00000, pwr}, 24'h000000);
    check(odd, 24'h000000);
    $display("t_reset done");
  endtask
  task automatic t_power;
    logic [7:0] vals [4] = '{8'h20, 8'h10, 8'h04, 8'h02};
    foreach (vals[i]) begin
      wr(8'h08, vals[i]);
      check({18'h00000, pwr}, {18'h00000, vals[i][5:4], 1'b0, vals[i][2:1], 1'b0});
      rd_chk(8'h08, vals[i]);
    end
    $display("t_power done");
  endtask
  task automatic t_global;
    logic [7:0] masks [5] = '{8'h00, 8'h08, 8'h04, 8'h02, 8'h0E};
    foreach (masks[i]) begin
      wr(8'h0D, masks[i]);
      wr(8'h08, 8'h01);
      check({18'h00000, pwr}, {18'h00000, ~masks[i][3:2], masks[i][1], 3'h7});
      rd_chk(8'h0D, masks[i]);
      wr(8'h08, 8'h00);
      check({18'h00000, pwr}, 24'h000000);
    end
    sel = 1'b0;
    pin = 1'b1;
    i_host.tick(5);
    check(pwr.global_sleep_active, 1'b1);
    sel = 1'b1;
    i_host.tick(5);
    check(pwr.global_sleep_active, 1'b0);
    pin = 1'b0;
    $display("t_global done");
  endtask
  task automatic t_modes;
    logic [2:0]  maps  [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    logic [2:0]  modes [4] = '{3'h3, 3'h3, 3'h4, 3'h5};
    logic [23:0] drv   [4] = '{24'h7FEEFC, 24'h7FEEFC, 24'hFFEEFD, 24'hFFEFFD};
    logic [2:0]  prev;
    prev = fuse_map;
    foreach (maps[i]) begin
      wr(8'h08, 8'h06);
      wr(8'h07, {maps[i], 2'h1, modes[i]});
      check(ifc.lane_mapping, prev);
      check(ifc.interface_mode, modes[i]);
      wr(8'h13, 8'h01);
      check(ifc.lane_mapping, maps[i]);
      rd_chk(8'h08, 8'h00);
      check({18'h00000, pwr}, 24'h000000);
      rd_chk(8'h07, {maps[i], 2'h1, modes[i]});
      wr(8'h0A, drv[i][23:16]);
      wr(8'h0B, drv[i][15:8]);
      wr(8'h0C, drv[i][7:0]);
      check(odd, drv[i]);
      check(bci_off, 1'b1);
      prev = maps[i];
    end
    $display("t_modes done");
  endtask
  task automatic t_override;
    wr(8'h07, 8'h03);
    check(ifc.interface_mode, fuse_mode);
    wr(8'h07, 8'h0F);
    check(ifc.interface_mode, fuse_mode);
    wr(8'h07, 8'hE0);
    wr(8'h13, 8'h01);
    check(ifc.lane_mapping, fuse_map);
    $display("t_override done");
  endtask
  task automatic t_refuse;
    fuse_map  = 3'h1;
    fuse_mode = 3'h5;
    i_host.tick(4);
    check({18'h00000, ifc}, {18'h00000, 3'h3, 3'h4});
    wr(8'h13, 8'h01);
    check({18'h00000, ifc}, {18'h00000, fuse_map, fuse_mode});
    fuse_map  = 3'h2;
    fuse_mode = 3'h3;
    rst_in    = 1'b1;
    i_host.tick(6);
    rst_in = 1'b0;
    i_host.tick(8);
    check({18'h00000, ifc}, {18'h00000, fuse_map, fuse_mode});
    rd_chk(8'h07, 8'h00);
    $display("t_refuse done");
  endtask
  task automatic t_bitclk;
    wr(8'h0A, 8'h00);
    check(bci_off, 1'b0);
    en_b = 1'b0;
    i_host.tick(3);
    check(bci_off, 1'b1);
    en_b = 1'b1;
    en_a = 1'b0;
    i_host.tick(3);
    check(bci_off, 1'b1);
    en_a = 1'b1;
    bco  = 1'b1;
    i_host.tick(3);
    check(bco_off, 1'b1);
    bco = 1'b0;
    i_host.tick(3);
    check({bci_off, bco_off}, 2'h0);
    $display("t_bitclk done");
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    i_host.tick(8);
    t_reset();
    t_power();
    t_global();
    t_modes();
    t_override();
    t_bitclk();
    t_refuse();
    print_verdict();
  end
  // Whole run is near 74 frames of 72 clocks each
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end
endmodule
